// >>> avc_pkg.sv
`default_nettype none
// ************
// constants
// ************
package avc_pkg;
    localparam logic [15:0] CTRL_ADDR      = 16'hA038;
    localparam logic [15:0] DAC0_L_ADDR    = 16'hA1A0;
    localparam logic [15:0] DAC0_R_ADDR    = 16'hA1A1;
    localparam logic [15:0] DAC1_L_ADDR    = 16'hA1A2;
    localparam logic [15:0] DAC1_R_ADDR    = 16'hA1A3;
    localparam logic [15:0] MIX_OUT_L_ADDR = 16'hA1A6;
    localparam logic [15:0] MIX_OUT_R_ADDR = 16'hA1A7;
    localparam logic [15:0] MIX_IN_L_ADDR  = 16'hA1A8;
    // control and volume bit positions, level widths
    localparam int RST_BIT    = 0;
    localparam int EN_BIT     = 1;
    localparam int DIG_BIT    = 2;
    localparam int AMP_BIT    = 3;
    localparam int MUTE_BIT   = 7;
    localparam int DAC_LVL_W  = 7;
    localparam int MIX_LVL_W  = 5;
    // reset values
    localparam logic [7:0] CTRL_RST    = 8'h00;
    localparam logic [7:0] DAC_VOL_RST = 8'h80;
    localparam logic [7:0] MIX_OUT_RST = 8'h80;
    localparam logic [7:0] MIX_IN_RST  = 8'h8C;
    // register slots
    localparam int NUM_REGS   = 8;
    localparam logic [2:0] SLOT_CTRL    = 3'h0;
    localparam logic [2:0] SLOT_DAC0_L  = 3'h1;
    localparam logic [2:0] SLOT_MIX_O_L = 3'h5;
    localparam logic [2:0] SLOT_MIX_I_L = 3'h7;
    // timing
    localparam int CLK_PERIOD_PS = 4000;
    localparam int RST_HOLD_NS   = 250;
    localparam int RST_CYC       = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W         = 7;
endpackage
`default_nettype wire

// >>> avc_rst_if.sv
`default_nettype none
// ************
// self-clearing reset handshake
// ************
interface avc_rst_if;
    logic start;
    logic busy;
    modport ctl (output start, input busy);
    modport tmr (input start, output busy);
endinterface
`default_nettype wire

// >>> avc_rst_timer.sv
`default_nettype none
module avc_rst_timer
    import avc_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // handshake
    avc_rst_if.tmr    rst_if
);
    typedef struct packed {
        logic             busy;
        logic [CNT_W-1:0] cnt;
    } avc_tmr_t;

    avc_tmr_t st;
    avc_tmr_t next_st;

    // ************
    // hold counter
    // ************
    always_comb begin
        next_st = st;
        if (rst_if.start) begin
            // a new request restarts the full hold
            next_st.busy = 1'b1;
            next_st.cnt  = CNT_W'(RST_CYC - 1);
        end else if (st.busy) begin
            if (st.cnt == '0) begin
                next_st.busy = 1'b0;
            end else begin
                next_st.cnt = st.cnt - CNT_W'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rst_if.busy = st.busy;
endmodule
`default_nettype wire

// >>> avc_regs.sv
`default_nettype none
// Notes on behaviour
// - Controls and volumes are 8-bit registers written and read one byte per access.
// - Writing one to control bit 0 resets the audio subsystem and the bit clears 250 ns later.
// - Control bit 1, reset zero, enables audio; zero holds the subsystem in low power.
// - Control bit 2 set turns the digital audio path off; reset value keeps it on.
// - Control bit 3 set turns speaker-amplifier digital processing off; reset keeps it on.
// - DAC0 volume bits 6:0 give 128 attenuation steps of 0.75 dB, resetting to zero.
// - Bit 7 of each volume register mutes its channel and resets to one.
// - DAC1 left and right volume registers match the DAC0 layout and reset values.
// - Mixer output volume bits 4:0 give 32 steps of 1.5 dB attenuation, resetting to zero.
// - DAC0 mixer-input gain bits 4:0 step 1 dB from +12 dB, with 0Ch as 0 dB and reset.
module avc_regs
    import avc_pkg::*;
(
    // clock and reset
    input  wire logic                   clk_i,
    input  wire logic                   sys_rst_i,
    // register port
    input  wire logic [15:0]            addr_i,
    input  wire logic                   wr_en_i,
    input  wire logic                   rd_en_i,
    input  wire logic [7:0]             wdata_i,
    output logic      [7:0]             rdata_o,
    output logic                        rd_valid_o,
    // subsystem control
    output logic                        audio_rst_o,
    output logic                        audio_en_o,
    output logic                        digital_path_off_o,
    output logic                        speaker_amp_digital_off_o,
    // volumes: index 0 dac0 left, 1 dac0 right, 2 dac1 left, 3 dac1 right
    output logic [3:0][DAC_LVL_W-1:0]   dac_level_o,
    output logic [3:0]                  dac_mute_o,
    output logic [1:0][MIX_LVL_W-1:0]   mix_out_level_o,
    output logic [1:0]                  mix_out_mute_o,
    output logic [MIX_LVL_W-1:0]        dac0_mixer_in_gain_left_o,
    output logic                        dac0_mixer_in_mute_left_o
);
    typedef struct packed {
        logic [NUM_REGS-1:0][7:0] regs;
        logic [7:0]               rdata;
        logic                     rd_valid;
    } avc_state_t;

    avc_state_t st;
    avc_state_t next_st;
    avc_rst_if  rst_if ();

    // ************
    // address decode
    // ************
    function automatic logic [3:0] decode(input logic [15:0] a);
        case (a)
            CTRL_ADDR:      decode = 4'h8;
            DAC0_L_ADDR:    decode = 4'h9;
            DAC0_R_ADDR:    decode = 4'hA;
            DAC1_L_ADDR:    decode = 4'hB;
            DAC1_R_ADDR:    decode = 4'hC;
            MIX_OUT_L_ADDR: decode = 4'hD;
            MIX_OUT_R_ADDR: decode = 4'hE;
            MIX_IN_L_ADDR:  decode = 4'hF;
            default:        decode = 4'h0;
        endcase
    endfunction

    logic [3:0] hit;
    assign hit = decode(addr_i);
    // a write of one to the reset bit starts the hold timer
    assign rst_if.start = wr_en_i && hit[3] && hit[2:0] == SLOT_CTRL
                          && wdata_i[RST_BIT];

    avc_rst_timer u_timer (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .rst_if    (rst_if)
    );

    // ************
    // register file
    // ************
    always_comb begin
        next_st          = st;
        next_st.rd_valid = rd_en_i;
        if (wr_en_i && hit[3]) begin
            // unmapped writes are dropped, so reserved spans stay harmless
            next_st.regs[hit[2:0]] = wdata_i;
            if (hit[2:0] == SLOT_CTRL) begin
                next_st.regs[SLOT_CTRL][RST_BIT] = 1'b0;
            end
        end
        if (rd_en_i) begin
            next_st.rdata = 8'h00;
            if (hit[3]) begin
                next_st.rdata = st.regs[hit[2:0]];
                if (hit[2:0] == SLOT_CTRL) begin
                    next_st.rdata[RST_BIT] = rst_if.busy;
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st.regs[0] <= CTRL_RST;
            st.regs[1] <= DAC_VOL_RST;
            st.regs[2] <= DAC_VOL_RST;
            st.regs[3] <= DAC_VOL_RST;
            st.regs[4] <= DAC_VOL_RST;
            st.regs[5] <= MIX_OUT_RST;
            st.regs[6] <= MIX_OUT_RST;
            st.regs[7] <= MIX_IN_RST;
            st.rdata    <= 8'h00;
            st.rd_valid <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ************
    // outputs
    // ************
    assign rdata_o                   = st.rdata;
    assign rd_valid_o                = st.rd_valid;
    assign audio_rst_o               = rst_if.busy;
    assign audio_en_o                = st.regs[SLOT_CTRL][EN_BIT];
    assign digital_path_off_o        = st.regs[SLOT_CTRL][DIG_BIT];
    assign speaker_amp_digital_off_o = st.regs[SLOT_CTRL][AMP_BIT];
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            dac_level_o[i] = st.regs[i + 1][DAC_LVL_W-1:0];
            dac_mute_o[i]  = st.regs[i + 1][MUTE_BIT];
        end
        for (int i = 0; i < 2; i++) begin
            mix_out_level_o[i] = st.regs[i + 5][MIX_LVL_W-1:0];
            mix_out_mute_o[i]  = st.regs[i + 5][MUTE_BIT];
        end
    end
    assign dac0_mixer_in_gain_left_o = st.regs[SLOT_MIX_I_L][MIX_LVL_W-1:0];
    assign dac0_mixer_in_mute_left_o = st.regs[SLOT_MIX_I_L][MUTE_BIT];

    // ************
    // assertions
    // ************
    logic [7:0] since_start;
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            since_start <= 8'hFF;
        end else if (rst_if.start) begin
            since_start <= 8'h01;
        end else if (since_start != 8'hFF) begin
            since_start <= since_start + 8'h01;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    sequence s_wr(logic [15:0] a);
        wr_en_i && addr_i == a;
    endsequence
    sequence s_rd(logic [15:0] a);
        rd_en_i && addr_i == a;
    endsequence

    a_rst_start_hold: assert property (rst_if.start |=> audio_rst_o [*8])
        else $error("reset bit did not hold after write");
    a_rst_self_clear: assert property (
        $fell(audio_rst_o) |-> since_start == 8'(RST_CYC + 1))
        else $error("reset bit cleared at wrong time");
    a_rst_read_back: assert property (
        s_rd(CTRL_ADDR) |=> rdata_o[RST_BIT] == $past(audio_rst_o))
        else $error("reset bit read back wrong");
    a_ctrl_enable: assert property (
        s_wr(CTRL_ADDR) |=> audio_en_o == $past(wdata_i[EN_BIT]))
        else $error("enable bit not stored");
    a_ctrl_dig_off: assert property (
        s_wr(CTRL_ADDR) |=> digital_path_off_o == $past(wdata_i[DIG_BIT]))
        else $error("digital path bit not stored");
    a_ctrl_amp_off: assert property (
        s_wr(CTRL_ADDR) |=> speaker_amp_digital_off_o == $past(wdata_i[AMP_BIT]))
        else $error("amplifier bit not stored");
    a_dac_vol_write: assert property (
        s_wr(DAC0_L_ADDR) |=> dac_level_o[0] == $past(wdata_i[6:0])
            && dac_mute_o[0] == $past(wdata_i[7]))
        else $error("dac0 left volume not stored");
    a_dac0_r_write: assert property (
        s_wr(DAC0_R_ADDR) |=> dac_level_o[1] == $past(wdata_i[6:0])
            && dac_mute_o[1] == $past(wdata_i[7]))
        else $error("dac0 right volume not stored");
    a_dac1_l_write: assert property (
        s_wr(DAC1_L_ADDR) |=> dac_level_o[2] == $past(wdata_i[6:0])
            && dac_mute_o[2] == $past(wdata_i[7]))
        else $error("dac1 left volume not stored");
    a_dac1_vol_write: assert property (
        s_wr(DAC1_R_ADDR) |=> dac_level_o[3] == $past(wdata_i[6:0])
            && dac_mute_o[3] == $past(wdata_i[7]))
        else $error("dac1 right volume not stored");
    a_mix_out_l_write: assert property (
        s_wr(MIX_OUT_L_ADDR) |=> mix_out_level_o[0] == $past(wdata_i[4:0])
            && mix_out_mute_o[0] == $past(wdata_i[7]))
        else $error("mixer output left volume not stored");
    a_mix_out_write: assert property (
        s_wr(MIX_OUT_R_ADDR) |=> mix_out_level_o[1] == $past(wdata_i[4:0])
            && mix_out_mute_o[1] == $past(wdata_i[7]))
        else $error("mixer output volume not stored");
    a_mix_in_gain: assert property (
        s_wr(MIX_IN_L_ADDR) |=> dac0_mixer_in_gain_left_o == $past(wdata_i[4:0])
            && dac0_mixer_in_mute_left_o == $past(wdata_i[7]))
        else $error("mixer input gain not stored");
    a_mix_in_write: assert property (
        s_wr(MIX_IN_L_ADDR) ##1 s_rd(MIX_IN_L_ADDR) |=> rdata_o == $past(wdata_i, 2))
        else $error("mixer input gain read back wrong");
    a_read_answer: assert property (
        rd_en_i && decode(addr_i) == 4'h0 |=> rd_valid_o && rdata_o == 8'h00)
        else $error("unmapped read not answered with zero");
    a_rd_valid_pulse: assert property (
        rd_valid_o == $past(rd_en_i))
        else $error("read valid not a one cycle answer");
    a_unmapped_write: assert property (
        wr_en_i && decode(addr_i) == 4'h0 |=> $stable(dac_mute_o) && $stable(dac_level_o)
            && $stable(audio_en_o))
        else $error("unmapped write changed a register");
    a_mute_at_reset: assert property (
        $fell(sys_rst_i) |-> dac_mute_o == 4'hF && mix_out_mute_o == 2'h3)
        else $error("channels not muted after reset");
endmodule
`default_nettype wire

// >>> avc_host_model.sv
`default_nettype none
// ************
// controller side of the register port
// ************
module avc_host_model
    import avc_pkg::*;
(
    // clock
    input  wire logic        clk_i,
    // register port
    output logic      [15:0] addr_o,
    output logic             wr_en_o,
    output logic             rd_en_o,
    output logic      [7:0]  wdata_o,
    input  wire logic [7:0]  rdata_i,
    input  wire logic        rd_valid_i
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        addr_o = 16'h0000;
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        wdata_o = 8'h00;
    end
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        if (a inside {[16'hA110:16'hA19F], [16'hA1A4:16'hA1A5],
                      [16'hA1CD:16'hA1EF]}) return;
        if (a == CTRL_ADDR) d[7:4] = 4'h0;
        if (a inside {[16'hA1A6:16'hA1A8]}) d[6:5] = 2'h0;
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_en_o = 1'b1;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        wdata_o = ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_i);
        addr_o = a;
        rd_en_o = 1'b1;
        @(negedge clk_i);
        rd_en_o = 1'b0;
        addr_o = ~a;
        v = rd_valid_i;
        d = rdata_i;
    endtask
    // write then read on the next edge; mapped addresses only
    task automatic wr_rd(input logic [15:0] a, input logic [7:0] wd, output logic [7:0] d,
                         output logic v);
        if (a inside {[16'hA1A6:16'hA1A8]}) wd[6:5] = 2'h0;
        @(negedge clk_i);
        addr_o = a;
        wdata_o = wd;
        wr_en_o = 1'b1;
        @(negedge clk_i);
        wr_en_o = 1'b0;
        wdata_o = ~wd;
        rd_en_o = 1'b1;
        @(negedge clk_i);
        rd_en_o = 1'b0;
        addr_o = ~a;
        v = rd_valid_i;
        d = rdata_i;
    endtask
endmodule
`default_nettype wire

// >>> tb_audio_volume_control_regs.sv
`default_nettype none
module tb_audio_volume_control_regs;
    import avc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, sys_rst_i = 1'b1, wr_en, rd_en, rd_valid, arst, aen, dig, amp, gmute;
    logic [15:0] addr;
    logic [7:0] wdata, rdata, d;
    logic [3:0][6:0] dlvl;
    logic [3:0] dmute;
    logic [1:0][4:0] mlvl;
    logic [1:0] mmute;
    logic [4:0] gain;
    logic v;
    logic [7:0] mdl [8] = '{8'h00, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h80, 8'h8C};
    logic [15:0] adr [8] = '{16'hA038, 16'hA1A0, 16'hA1A1, 16'hA1A2, 16'hA1A3,
                             16'hA1A6, 16'hA1A7, 16'hA1A8};
    int failures = 0, samples_checked = 0, cycles = 0, n, s;
    always #2 clk_i = ~clk_i;
    avc_host_model host (.clk_i(clk_i), .addr_o(addr), .wr_en_o(wr_en), .rd_en_o(rd_en),
        .wdata_o(wdata), .rdata_i(rdata), .rd_valid_i(rd_valid));
    avc_regs uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr), .wr_en_i(wr_en),
        .rd_en_i(rd_en), .wdata_i(wdata), .rdata_o(rdata), .rd_valid_o(rd_valid),
        .audio_rst_o(arst), .audio_en_o(aen), .digital_path_off_o(dig),
        .speaker_amp_digital_off_o(amp), .dac_level_o(dlvl), .dac_mute_o(dmute),
        .mix_out_level_o(mlvl), .mix_out_mute_o(mmute), .dac0_mixer_in_gain_left_o(gain),
        .dac0_mixer_in_mute_left_o(gmute));
    // bits the controller is allowed to change; bit0 of control is never stored
    function automatic logic [7:0] wmask(int k);
        return (k == 0) ? 8'h0E : ((k >= 5) ? 8'h9F : 8'hFF);
    endfunction
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            failures++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic verify_all;
        for (int k = 0; k < 8; k++) begin
            host.rd(adr[k], d, v);
            check({7'h00, v}, 8'h01);
            check(d, mdl[k]);
        end
        check({5'h00, amp, dig, aen}, {5'h00, mdl[0][3:1]});
        for (int k = 0; k < 4; k++) check({dmute[k], dlvl[k]}, mdl[k+1]);
        for (int k = 0; k < 2; k++) check({mmute[k], 2'h0, mlvl[k]}, mdl[k+5]);
        check({gmute, 2'h0, gain}, mdl[7]);
        check({7'h00, arst}, 8'h00);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    initial begin
        void'($urandom(24));
        repeat (5) @(posedge clk_i);
        @(negedge clk_i) sys_rst_i = 1'b0;
        verify_all();
        $display("test reset values done");
        host.wr(16'hA000, 8'hFF);
        foreach (adr[k]) begin
            host.rd(k[0] ? 16'hA1A4 : 16'hA110, d, v);
            check({7'h00, v}, 8'h01);
            check(d, 8'h00);
        end
        verify_all();
        $display("test unmapped done");
        for (int i = 0; i < 60; i++) begin
            s = $urandom_range(7, 0);
            // corner codes first: max level unmuted, full scale, zero
            d = (i < 8) ? 8'h7F : ((i < 16) ? 8'hFF : ((i < 24) ? 8'h00 : 8'($urandom)));
            if (i < 24) s = i % 8;
            d = d & ((s == 0) ? 8'hFE : 8'hFF);
            host.wr(adr[s], d);
            mdl[s] = d & wmask(s);
            if (i % 15 == 14) verify_all();
        end
        // write and read back on adjacent edges: +12 dB code, then full cut with mute
        host.wr_rd(MIX_IN_L_ADDR, 8'h00, d, v);
        check(d, 8'h00);
        check({7'h00, v}, 8'h01);
        host.wr_rd(MIX_IN_L_ADDR, 8'h9F, d, v);
        check(d, 8'h9F);
        mdl[7] = 8'h9F;
        verify_all();
        $display("test random volumes done");
        host.wr(CTRL_ADDR, mdl[0] | 8'h01);
        n = 0;
        while (arst === 1'b1 && n < 200) begin
            n++;
            @(negedge clk_i);
        end
        check(8'(n), 8'd63);
        host.wr(CTRL_ADDR, mdl[0] | 8'h01);
        host.rd(CTRL_ADDR, d, v);
        check(d, mdl[0] | 8'h01);
        repeat (70) @(negedge clk_i);
        verify_all();
        $display("test self clear done");
        conclude();
    end
endmodule
`default_nettype wire
